// >>> bench/pbap_bridge_tb.sv
// pbap_bridge_tb: bridge with a peripheral model, driven as an APB master.
// assumes register map in slot 0 and slot number in paddr[17:14].
`timescale 1ns/1ps
module pbap_bridge_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, per_write, per_super;
    logic per_ready, per_err, err_on, last_sup, gerr;
    logic [31:0] paddr, pwdata, prdata, per_wdata, per_rdata, got, last_wd;
    logic [3:0] pstrb, per_strb, dly, last_strb;
    logic [2:0] pprot, pmaster;
    logic [15:0] per_sel, last_sel;
    logic [13:0] per_addr;
    int err_count, num_checks, nsel, clks;
    pbap_bridge DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
        .pmaster(pmaster), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .per_sel(per_sel), .per_addr(per_addr), .per_write(per_write), .per_wdata(per_wdata),
        .per_strb(per_strb), .per_super(per_super), .per_rdata(per_rdata),
        .per_ready(per_ready), .per_err(per_err));
    pbap_per_model PER (.pclk(pclk), .presetn(presetn), .per_sel(per_sel), .per_addr(per_addr),
        .per_rdata(per_rdata), .per_ready(per_ready), .per_err(per_err), .dly(dly), .err_on(err_on));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // peripheral bus activity seen by the bench
    always @(posedge pclk)
    begin
        if (per_sel != 16'h0000)
        begin
            nsel <= nsel + 1;
            last_sel <= per_sel;
            last_sup <= per_super;
            last_wd <= per_wdata;
            last_strb <= per_strb;
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] pr,
        input logic [2:0] m);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= pr;
        pmaster <= m;
        @(posedge pclk);
        penable <= 1'b1;
        // pready comes from the state flop, so at the edge it still shows the sampled value
        for (i = 0; i < 30; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 30)
        begin
            err_count++;
            $display("wrong value at %0t: no answer from the bridge", $time);
            report_and_stop();
        end
        got = prdata;
        gerr = pslverr;
        clks = i + 2;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rreg(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 3'h1, 3'h0);
        chk(got, e);
        chk(gerr, 1'b0);
        chk(clks, 2);
    endtask
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 3'h1, 3'h0);
        chk(gerr, 1'b0);
        chk(clks, 3);
    endtask
    task automatic acc(input logic w, input logic [3:0] s, input logic [2:0] pr, input logic [2:0] m,
        input logic e);
        int n;
        n = nsel;
        apb(w, {14'h0, s, 14'h0010}, 32'hC3A5_0F1E, pr, m);
        chk(gerr, e);
        if (e)
        begin
            chk(got, 32'h0);
            chk(nsel - n, 0);
        end
        else
        begin
            chk(last_sel, 16'h0001 << s);
            chk(nsel != n, 1'b1);
            if (!w)
                chk(got, 32'h5A5A_0010);
        end
    endtask
    task automatic t_reset;
        rreg(32'h00, 32'h7700_0000);
        rreg(32'h20, 32'h4444_4440);
        rreg(32'h40, 32'h4444_4440);
        rreg(32'h10, 32'h0000_0000);
    endtask
    task automatic t_regs;
        wreg(32'h00, 32'h71FF_FFFF);
        rreg(32'h00, 32'h7100_0000);
        wreg(32'h20, 32'hC021_4FFF);
        rreg(32'h20, 32'h4021_4770);
        wreg(32'h40, 32'h27FF_FFFF);
        rreg(32'h40, 32'h2777_7770);
    endtask
    task automatic t_timing;
        pstrb <= 4'h6;
        for (int d = 0; d < 4; d++)
        begin
            dly <= d[3:0];
            acc(1'b0, 4'h1, 3'h1, 3'h0, 1'b0);
            chk(clks, d + 2);
            chk(last_sup, 1'b1);
            acc(1'b1, 4'h1, 3'h1, 3'h0, 1'b0);
            chk(clks, d + 3);
        end
        chk(last_wd, 32'hC3A5_0F1E);
        chk(last_strb, 4'h6);
        acc(1'b0, 4'h1, 3'h0, 3'h0, 1'b0);
        chk(last_sup, 1'b0);
        pstrb <= 4'hF;
    endtask
    task automatic t_abort;
        err_on <= 1'b1;
        for (int d = 0; d < 3; d += 2)
        begin
            dly <= d[3:0];
            apb(1'b0, 32'h4010, 32'h0, 3'h1, 3'h0);
            chk(gerr, 1'b1);
            chk(got, 32'h0);
            chk(clks, d + 2);
            apb(1'b1, 32'h4010, 32'h1, 3'h1, 3'h0);
            chk(gerr, 1'b1);
            chk(clks, d + 3);
        end
        err_on <= 1'b0;
        dly <= 4'h0;
    endtask
    task automatic t_guard;
        acc(1'b1, 4'h2, 3'h1, 3'h0, 1'b1);
        acc(1'b0, 4'h2, 3'h1, 3'h0, 1'b0);
        acc(1'b0, 4'h4, 3'h0, 3'h0, 1'b1);
        acc(1'b0, 4'h4, 3'h1, 3'h0, 1'b0);
        acc(1'b0, 4'h0, 3'h0, 3'h0, 1'b1);
        acc(1'b1, 4'h8, 3'h1, 3'h0, 1'b1);
        acc(1'b0, 4'h8, 3'h1, 3'h0, 1'b0);
        acc(1'b0, 4'h9, 3'h0, 3'h0, 1'b1);
    endtask
    task automatic t_masters;
        acc(1'b0, 4'h3, 3'h1, 3'h1, 1'b1);
        acc(1'b1, 4'h3, 3'h1, 3'h1, 1'b1);
        acc(1'b0, 4'h3, 3'h1, 3'h0, 1'b0);
        acc(1'b0, 4'h4, 3'h1, 3'h1, 1'b0);
        wreg(32'h00, 32'h7600_0000);
        acc(1'b0, 4'h3, 3'h1, 3'h1, 1'b0);
        acc(1'b1, 4'h3, 3'h1, 3'h1, 1'b0);
        acc(1'b0, 4'h4, 3'h1, 3'h1, 1'b1);
        acc(1'b0, 4'h1, 3'h1, 3'h1, 1'b0);
        chk(last_sup, 1'b0);
        wreg(32'h00, 32'h7200_0000);
        acc(1'b0, 4'h3, 3'h1, 3'h1, 1'b1);
        acc(1'b1, 4'h3, 3'h1, 3'h1, 1'b0);
    endtask
    task automatic t_decode;
        acc(1'b0, 4'h7, 3'h1, 3'h0, 1'b1);
        acc(1'b0, 4'hF, 3'h1, 3'h0, 1'b1);
        acc(1'b0, 4'h6, 3'h1, 3'h0, 1'b0);
        acc(1'b0, 4'hE, 3'h1, 3'h0, 1'b0);
        apb(1'b0, 32'h0010_4010, 32'h0, 3'h1, 3'h0);
        chk(gerr, 1'b1);
        chk(got, 32'h0);
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        pprot = 3'h0;
        pmaster = 3'h0;
        dly = 4'h0;
        err_on = 1'b0;
        err_count = 0;
        num_checks = 0;
        nsel = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_timing();
        t_abort();
        t_guard();
        t_masters();
        t_decode();
        report_and_stop();
    end
endmodule

// >>> bench/pbap_per_model.sv
// pbap_per_model: peripheral bus slave standing behind the bridge.
// assumes the select is held until ready or error; answers dly cycles late.
`timescale 1ns/1ps
module pbap_per_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // peripheral bus
    input wire logic [15:0] per_sel,
    input wire logic [13:0] per_addr,
    output logic [31:0] per_rdata,
    output logic per_ready,
    output logic per_err,
    // bench control
    input wire logic [3:0] dly,
    input wire logic err_on
);
    logic [3:0] cnt_r;
    logic tog_r;
    logic done;
    assign done = (per_sel != 16'h0000) && (cnt_r == dly);
    assign per_ready = done && !err_on;
    assign per_err = done && err_on;
    // idle data toggles so a stale word never passes for an answer
    assign per_rdata = per_ready ? ({18'h0, per_addr} ^ 32'h5A5A_0000) : {32{tog_r}};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 4'h0;
            tog_r <= 1'b0;
        end
        else
        begin
            tog_r <= !tog_r;
            cnt_r <= (done || per_sel == 16'h0000) ? 4'h0 : cnt_r + 4'h1;
        end
    end
endmodule

// >>> verilog/pbap_bridge.sv
// pbap_bridge: APB system-side slave, guard checks, bridge registers and peripheral bus master.
// assumes masters hold each APB request until pready; peripherals answer with per_ready or per_err.
`timescale 1ns/1ps
module pbap_bridge
    import pbap_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // system-side apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [2:0] pmaster,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // peripheral bus
    output logic [15:0] per_sel,
    output logic [13:0] per_addr,
    output logic per_write,
    output logic [31:0] per_wdata,
    output logic [3:0] per_strb,
    output logic per_super,
    input wire logic [31:0] per_rdata,
    input wire logic per_ready,
    input wire logic per_err
);

    function automatic logic [3:0] fld(input logic [31:0] v, input logic [2:0] i);
        fld = v[{3'h7 - i, 2'b00} +: 4];
    endfunction

    function automatic logic [31:0] present_mask(input logic [7:0] p);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 8; i++)
        begin
            if (p[i])
                m[4 * (7 - i) +: 4] = 4'hF;
        end
        present_mask = m & PBAP_FIELD_MASK;
    endfunction

    localparam logic [31:0] PAC_MASK = present_mask(PBAP_SLOT_PRESENT[7:0]);
    localparam logic [31:0] OPAC_MASK = present_mask(PBAP_SLOT_PRESENT[15:8]);

    pbap_regs_t r_r;
    pbap_regs_t r_nxt;
    pbap_per_req_t live;
    logic [3:0] slot;
    logic mapped;
    logic [3:0] mf;
    logic [3:0] gf;
    logic sup_acc;
    logic trusted;
    logic viol;
    logic setup;
    logic launch;
    logic [31:0] reg_rd;

    // decode and guard checks
    always_comb
    begin
        setup = psel & ~penable;
        slot = paddr[PBAP_SLOT_LSB +: 4];
        mapped = (paddr[31:18] == 14'h0000) && PBAP_SLOT_PRESENT[slot];
        // processor is index 0, dma index 1; others get an all-zero field
        mf = (pmaster < PBAP_MASTERS) ? fld(r_r.mpr, pmaster) : 4'h0;
        sup_acc = pprot[0] & mf[PBAP_PASS];
        trusted = pwrite ? mf[PBAP_WR_TRUST] : mf[PBAP_RD_TRUST];
        gf = slot[3] ? fld(r_r.opacr, slot[2:0]) : fld(r_r.pacr, slot[2:0]);
        viol = (gf[PBAP_SUPER_ONLY] & ~sup_acc)
            | (gf[PBAP_WRITE_PROT] & pwrite)
            | (gf[PBAP_TRUST_ONLY] & ~trusted);
        live.sel = (slot != 4'h0) ? (16'h0001 << slot) : 16'h0000;
        live.addr = paddr[13:0];
        live.write = pwrite;
        live.wdata = pwdata;
        live.strb = pstrb;
        live.sup_mode = sup_acc;
        reg_rd = 32'h0000_0000;
        if (paddr[13:0] == PBAP_OFF_MPR)
            reg_rd = r_r.mpr;
        else if (paddr[13:0] == PBAP_OFF_PACR)
            reg_rd = r_r.pacr;
        else if (paddr[13:0] == PBAP_OFF_OPACR)
            reg_rd = r_r.opacr;
        // reads start the peripheral in the setup cycle so they can finish in two clocks
        launch = (r_r.st == PBAP_IDLE) && setup && mapped && !viol && (slot != 4'h0) && !pwrite;
    end

    // next state
    always_comb
    begin
        r_nxt = r_r;
        case (r_r.st)
            PBAP_IDLE:
            begin
                if (setup)
                begin
                    r_nxt.err = 1'b0;
                    r_nxt.rdata = 32'h0000_0000;
                    r_nxt.st = PBAP_RESP;
                    if (!mapped || viol)
                    begin
                        r_nxt.err = 1'b1;
                    end
                    else if (slot == 4'h0)
                    begin
                        r_nxt.rdata = pwrite ? 32'h0000_0000 : reg_rd;
                        r_nxt.st = pwrite ? PBAP_WAIT : PBAP_RESP;
                    end
                    else if (pwrite)
                    begin
                        // writes go out registered, the answer comes on the third clock at the earliest
                        r_nxt.req = live;
                        r_nxt.st = PBAP_PER;
                    end
                    else if (per_err)
                    begin
                        r_nxt.err = 1'b1;
                    end
                    else if (per_ready)
                    begin
                        r_nxt.rdata = per_rdata;
                    end
                    else
                    begin
                        r_nxt.req = live;
                        r_nxt.st = PBAP_PER;
                    end
                end
            end
            PBAP_PER:
            begin
                if (per_err)
                begin
                    // single and multi-cycle peripheral accesses end the same way
                    r_nxt.err = 1'b1;
                    r_nxt.rdata = 32'h0000_0000;
                    r_nxt.req = '0;
                    r_nxt.st = PBAP_RESP;
                end
                else if (per_ready)
                begin
                    r_nxt.rdata = r_r.req.write ? 32'h0000_0000 : per_rdata;
                    r_nxt.req = '0;
                    r_nxt.st = PBAP_RESP;
                end
            end
            PBAP_WAIT:
            begin
                r_nxt.st = PBAP_RESP;
            end
            PBAP_RESP:
            begin
                r_nxt.st = PBAP_IDLE;
                // register writes land on the edge that samples pready
                if (psel && penable && pwrite && !r_r.err && mapped && slot == 4'h0)
                begin
                    if (paddr[13:0] == PBAP_OFF_MPR)
                        r_nxt.mpr = pwdata & PBAP_MPR_MASK;
                    else if (paddr[13:0] == PBAP_OFF_PACR)
                        r_nxt.pacr = pwdata & PAC_MASK;
                    else if (paddr[13:0] == PBAP_OFF_OPACR)
                        r_nxt.opacr = pwdata & OPAC_MASK;
                end
            end
            default:
            begin
                r_nxt.st = PBAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_r.st <= PBAP_IDLE;
            r_r.req <= '0;
            r_r.mpr <= PBAP_MPR_RST;
            r_r.pacr <= PBAP_GUARD_RST & PAC_MASK;
            r_r.opacr <= PBAP_GUARD_RST & OPAC_MASK;
            r_r.rdata <= 32'h0000_0000;
            r_r.err <= 1'b0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // outputs; the live read path trades a combinational select for the two-clock read
    always_comb
    begin
        pready = (r_r.st == PBAP_RESP);
        pslverr = pready & r_r.err;
        prdata = r_r.rdata;
        if (launch)
        begin
            per_sel = live.sel;
            per_addr = live.addr;
            per_write = live.write;
            per_wdata = live.wdata;
            per_strb = live.strb;
            per_super = live.sup_mode;
        end
        else
        begin
            per_sel = r_r.req.sel;
            per_addr = r_r.req.addr;
            per_write = r_r.req.write;
            per_wdata = r_r.req.wdata;
            per_strb = r_r.req.strb;
            per_super = r_r.req.sup_mode;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reg_read_two;
        (r_r.st == PBAP_IDLE) && setup && !pwrite && mapped && !viol && slot == 4'h0
            |=> pready && !pslverr;
    endproperty
    a_reg_read_two: assert property (p_reg_read_two) else $error("register read not done in two clocks");

    property p_per_read_two;
        launch && per_ready && !per_err |=> pready && !pslverr && prdata == $past(per_rdata);
    endproperty
    a_per_read_two: assert property (p_per_read_two) else $error("peripheral read not done in two clocks");

    property p_write_three;
        (r_r.st == PBAP_IDLE) && setup && pwrite && mapped && !viol |=> !pready ##1 (pready || per_sel != 0);
    endproperty
    a_write_three: assert property (p_write_three) else $error("write answered too early or stalled");

    property p_viol_abort;
        (r_r.st == PBAP_IDLE) && setup && mapped && viol |-> per_sel == 16'h0000 ##1 pready && pslverr;
    endproperty
    a_viol_abort: assert property (p_viol_abort) else $error("guard violation not aborted");

    property p_unmapped;
        (r_r.st == PBAP_IDLE) && setup && !mapped |-> per_sel == 16'h0000 ##1 pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("empty slot access not aborted");

    property p_per_err;
        (per_sel != 16'h0000) && per_err |=> pready && pslverr && per_sel == 16'h0000;
    endproperty
    a_per_err: assert property (p_per_err) else $error("peripheral error not ended at once");

    property p_abort_zero;
        pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_abort_zero: assert property (p_abort_zero) else $error("aborted access returned data");

    property p_super_pass;
        launch |-> per_super == (pprot[0] && r_r.mpr[{3'h7 - pmaster, 2'b00}] && pmaster < PBAP_MASTERS);
    endproperty
    a_super_pass: assert property (p_super_pass) else $error("privilege attribute wrong");

    property p_write_prot;
        (r_r.st == PBAP_IDLE) && setup && pwrite && mapped && gf[PBAP_WRITE_PROT] |=> pslverr;
    endproperty
    a_write_prot: assert property (p_write_prot) else $error("write to protected peripheral passed");

    property p_reserved;
        (r_r.mpr & ~PBAP_MPR_MASK) == 0 && (r_r.pacr & ~PAC_MASK) == 0 && (r_r.opacr & ~OPAC_MASK) == 0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit became set");

    property p_onehot;
        $onehot0(per_sel) && !per_sel[0];
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one peripheral selected");

    c_fast_read: cover property (launch && per_ready);
    c_per_write: cover property ((r_r.st == PBAP_PER) && per_write && per_ready);
    c_per_err: cover property ((r_r.st == PBAP_PER) && per_err);
    c_violation: cover property ((r_r.st == PBAP_IDLE) && setup && mapped && viol);

endmodule

// >>> verilog/pbap_pkg.sv
// pbap_pkg: constants, register map and types of the peripheral bridge with access protection.
// assumes one APB system-side port, one peripheral bus, single clock pclk.
// How it works
// - one 4-bit guard field per master, eight per master protection word, bit 3 reserved
// - master field bit 2 set marks the master trusted for reads
// - master field bit 1 set marks the master trusted for writes
// - master field bit 0 clear forces user mode, set passes privilege through
// - unimplemented fields and reserved bits read zero and ignore writes
// - one 4-bit guard field per on-chip peripheral, eight per word, bit 3 reserved
// - supervisor-only peripheral needs supervisor access with pass-through set, else error
// - write-protected peripheral answers every write with error, no peripheral cycle
// - trusted-only peripheral rejects masters untrusted for that direction with error
// - off-chip peripherals use the same guard field layout and checks
// - accesses decode into one select per peripheral slot
// - aligned word, halfword, byte accesses pass unchecked; masters keep alignment
// - a read can finish in two clocks
// - a write can finish in three clocks
// - a peripheral error ends the access at once with error to the master
// - a guard violation starts no peripheral cycle and answers with error
// - an access to an empty slot starts nothing and answers with error
// - reset: masters trusted and passing privilege, peripherals supervisor-only
// - each peripheral is told whether the access is supervisor or user
// - processor is master zero, DMA controller master one
package pbap_pkg;

    // slots 0-7 on-chip (slot 0 is the bridge itself), 8-15 off-chip
    localparam logic [15:0] PBAP_SLOT_PRESENT = 16'h7F7F;
    localparam logic [2:0] PBAP_MASTERS = 3'h2;
    localparam int PBAP_SLOT_LSB = 14;

    localparam logic [13:0] PBAP_OFF_MPR = 14'h0000;
    localparam logic [13:0] PBAP_OFF_PACR = 14'h0020;
    localparam logic [13:0] PBAP_OFF_OPACR = 14'h0040;

    localparam logic [31:0] PBAP_MPR_MASK = 32'h7700_0000;
    localparam logic [31:0] PBAP_MPR_RST = 32'h7700_0000;
    localparam logic [31:0] PBAP_GUARD_RST = 32'h4444_4444;
    localparam logic [31:0] PBAP_FIELD_MASK = 32'h7777_7777;

    localparam int PBAP_RD_TRUST = 2;
    localparam int PBAP_WR_TRUST = 1;
    localparam int PBAP_PASS = 0;
    localparam int PBAP_SUPER_ONLY = 2;
    localparam int PBAP_WRITE_PROT = 1;
    localparam int PBAP_TRUST_ONLY = 0;

    localparam int PBAP_READ_CYCLES = 2;
    localparam int PBAP_WRITE_CYCLES = 3;

    typedef enum logic [1:0] {
        PBAP_IDLE = 2'b00,
        PBAP_PER = 2'b01,
        PBAP_WAIT = 2'b10,
        PBAP_RESP = 2'b11
    } pbap_state_t;

    typedef struct packed {
        logic [15:0] sel;
        logic [13:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic sup_mode;
    } pbap_per_req_t;

    typedef struct packed {
        pbap_state_t st;
        pbap_per_req_t req;
        logic [31:0] mpr;
        logic [31:0] pacr;
        logic [31:0] opacr;
        logic [31:0] rdata;
        logic err;
    } pbap_regs_t;

endpackage
